// ==== lbsd_device_end.sv ====
// Device end: selects, decodes and answers local bus cycles.
// Assumes host keeps maximum-mode status and external window decode.
`timescale 1ns/10ps
`include "lbsd_params.svh"
module lbsd_device_end
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bus
   lbsd_bus_if.device bus,
   // Kernel support unit side
   output logic accValid,
   output logic accWrite,
   output logic accIo,
   output logic accIntAck,
   output logic [13:0] memOffset,
   output logic [3:0] ioOffset,
   output logic [15:0] wrData,
   output logic upperLane,
   output logic wideHost,
   input wire logic [15:0] rdDataIn,
   input wire logic [7:0] vecWriteIdx,
   output logic vecWriteAllowed
);
   //==========================================
   // Cycle start and latches
   logic [2:0] statusPrev;
   logic [2:0] statusLat;
   logic memSelLat;
   logic ioSelLat;
   logic laneLat;
   logic [15:0] addrLat;
   logic active;
   logic driving;
   logic wideSeen;
   logic [1:0] stage;
   function automatic logic isPassive(input logic [2:0] st);
      isPassive = st == `LBSD_ST_PASSIVE;
   endfunction : isPassive
   function automatic logic isRead(input logic [2:0] st);
      isRead = st == `LBSD_ST_IORD || st == `LBSD_ST_MEMRD || st == `LBSD_ST_FETCH;
   endfunction : isRead
   function automatic logic isWrite(input logic [2:0] st);
      isWrite = st == `LBSD_ST_IOWR || st == `LBSD_ST_MEMWR;
   endfunction : isWrite
   // A cycle opens when status leaves passive and closes when it returns there
   wire cycleStart = isPassive(statusPrev) && !isPassive(bus.cpu_bus_cycle_status);
   wire cycleEnd = !isPassive(statusPrev) && isPassive(bus.cpu_bus_cycle_status);
   //==========================================
   // Decode
   wire memCycle = !memSelLat && (statusLat[2] && statusLat != `LBSD_ST_PASSIVE);
   wire ioCycle = !ioSelLat && (statusLat == `LBSD_ST_IORD || statusLat == `LBSD_ST_IOWR);
   wire ackCycle = statusLat == `LBSD_ST_INTA;
   wire selected = memCycle || ioCycle;
   assign memOffset = addrLat[`LBSD_MEM_OFS_W-1:0];
   assign ioOffset = addrLat[`LBSD_IO_OFS_W-1:0];
   assign upperLane = !laneLat;
   assign wideHost = wideSeen;
   assign accIo = ioCycle;
   assign accWrite = isWrite(statusLat);
   assign accIntAck = active && ackCycle;
   assign vecWriteAllowed = vecWriteIdx < `LBSD_VEC_USER_LO;
   assign bus.devAdOut = wrData;
   assign bus.devAdOe = driving;
   //==========================================
   // Next values
   // Release on cycle end wins over a read answer in the same clock
   wire readTurn = active && !cycleStart && stage == 2'h0 && selected && isRead(statusLat);
   wire writeTurn = active && !cycleStart && stage == 2'h1 && selected && isWrite(statusLat);
   wire closing = active && !cycleStart && cycleEnd;
   wire next_active = cycleStart || (active && !closing);
   wire [1:0] next_stage = cycleStart ? 2'h0
                           : ((active && stage != 2'h3) ? stage + 2'h1 : stage);
   wire next_driving = !closing && (readTurn || driving);
   wire next_accValid = readTurn || writeTurn;
   wire [15:0] next_wrData = readTurn ? rdDataIn : (writeTurn ? bus.adIn : wrData);
   wire next_wideSeen = wideSeen || (cycleStart && !bus.upper_byte_lane_enable_n);
   //==========================================
   // Status history
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         statusPrev <= `LBSD_ST_PASSIVE;
      end
      else
      begin
         statusPrev <= bus.cpu_bus_cycle_status;
      end
   end
   //==========================================
   // Cycle latches, the address is only valid in T1 and the selects are captured with it
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         statusLat <= `LBSD_ST_PASSIVE;
      end
      else if (cycleStart)
      begin
         statusLat <= bus.cpu_bus_cycle_status;
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         memSelLat <= 1'b1;
      end
      else if (cycleStart)
      begin
         memSelLat <= bus.memory_window_select_n;
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ioSelLat <= 1'b1;
      end
      else if (cycleStart)
      begin
         ioSelLat <= bus.io_window_select_n;
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         laneLat <= 1'b1;
      end
      else if (cycleStart)
      begin
         laneLat <= bus.upper_byte_lane_enable_n;
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addrLat <= 16'h0000;
      end
      else if (cycleStart)
      begin
         addrLat <= bus.adIn;
      end
   end
   //==========================================
   // Cycle tracking, open until status returns passive
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         active <= 1'b0;
      end
      else
      begin
         active <= next_active;
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stage <= 2'h0;
      end
      else
      begin
         stage <= next_stage;
      end
   end
   //==========================================
   // Bus drive and kernel support unit strobe
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         driving <= 1'b0;
         accValid <= 1'b0;
         wrData <= 16'h0000;
      end
      else
      begin
         driving <= next_driving;
         accValid <= next_accValid;
         wrData <= next_wrData;
      end
   end
   //==========================================
   // Host width detection, sticky once the upper lane is seen enabled
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wideSeen <= 1'b0;
      end
      else
      begin
         wideSeen <= next_wideSeen;
      end
   end
endmodule : lbsd_device_end

// ==== lbsd_params.svh ====
// Constants for the local bus select and decode block.
// Assumes inclusion by both bus ends and the package-free users alike.
`ifndef LBSD_PARAMS_SVH
`define LBSD_PARAMS_SVH
// Status codes on cpu_bus_cycle_status (active low encoded)
`define LBSD_ST_INTA 3'h0
`define LBSD_ST_IORD 3'h1
`define LBSD_ST_IOWR 3'h2
`define LBSD_ST_HALT 3'h3
`define LBSD_ST_FETCH 3'h4
`define LBSD_ST_MEMRD 3'h5
`define LBSD_ST_MEMWR 3'h6
`define LBSD_ST_PASSIVE 3'h7
// Address field widths and window limits
`define LBSD_MEM_OFS_W 14
`define LBSD_IO_OFS_W 4
`define LBSD_MEM_BLOCK_TOP 6'h3F
`define LBSD_MEM_BLOCK_LOW 6'h00
`define LBSD_IO_BASE_W 12
// Firmware-reserved vector range kept untouched
`define LBSD_VEC_USER_LO 8'hE0
`define LBSD_VEC_USER_HI 8'hFF
// Clock and zero-wait limit
`define LBSD_CLK_PERIOD_NS 100
`define LBSD_MAX_HOST_MHZ 8
`endif

// ==== lbsd_pkg.sv ====
// Types for the bus ends; only the host end uses the phase type.
// Assumes lbsd_params.svh for the numeric constants.
package lbsd_pkg;
   typedef enum logic [1:0] {LBSD_T1, LBSD_T2, LBSD_T3, LBSD_T4} lbsd_phase_e;
   typedef enum logic [1:0] {LBSD_SEL_NONE, LBSD_SEL_MEM, LBSD_SEL_IO} lbsd_sel_e;
endpackage : lbsd_pkg

// ==== lbsd_bus_if.sv ====
// Local multiplexed bus between the host processor and the coprocessor.
// Assumes one clock shared by both ends; adIn is resolved here from the two drivers.
`timescale 1ns/10ps
interface lbsd_bus_if
(
   input wire logic clock
);
   logic [2:0] cpu_bus_cycle_status;
   logic memory_window_select_n;
   logic io_window_select_n;
   logic upper_byte_lane_enable_n;
   logic readyIn;
   logic [15:0] hostAdOut;
   logic hostAdOe;
   logic [15:0] devAdOut;
   logic devAdOe;
   logic [15:0] adIn;
   assign adIn = devAdOe ? devAdOut : (hostAdOe ? hostAdOut : 16'h0000);
   modport host
   (
      output cpu_bus_cycle_status, memory_window_select_n, io_window_select_n,
      output upper_byte_lane_enable_n, hostAdOut, hostAdOe,
      input adIn, readyIn
   );
   modport device
   (
      input cpu_bus_cycle_status, memory_window_select_n, io_window_select_n,
      input upper_byte_lane_enable_n, adIn, readyIn,
      output devAdOut, devAdOe
   );
endinterface : lbsd_bus_if

// ==== lbsd_host_end.sv ====
// Host end: maximum-mode bus master with external window decoders.
// Assumes user requests held until done; waitStates stretches T3.
`timescale 1ns/10ps
`include "lbsd_params.svh"
module lbsd_host_end
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bus
   lbsd_bus_if.host bus,
   // User request
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqIo,
   input wire logic reqWide,
   input wire logic [19:0] reqAddr,
   input wire logic [15:0] reqData,
   input wire logic [1:0] waitStates,
   input wire logic [5:0] memBlock,
   input wire logic [11:0] ioBase,
   // User answer
   output logic reqDone,
   output logic [15:0] rdData,
   output logic mapError
);
   //==========================================
   // Decoders
   lbsd_pkg::lbsd_phase_e phase;
   logic [19:0] addr;
   logic write, io, wide, busy;
   logic [1:0] waitCnt;
   wire memHit = !io && addr[19:14] == memBlock;
   wire ioHit = io && addr[15:4] == ioBase;
   wire badMap = memBlock == `LBSD_MEM_BLOCK_TOP || memBlock == `LBSD_MEM_BLOCK_LOW;
   wire [2:0] stCode = io ? (write ? `LBSD_ST_IOWR : `LBSD_ST_IORD)
                          : (write ? `LBSD_ST_MEMWR : `LBSD_ST_MEMRD);
   assign bus.memory_window_select_n = !(busy && memHit && !badMap);
   assign bus.io_window_select_n = !(busy && ioHit);
   // Status stays encoded until T4 so the device sees where a stretched cycle ends
   assign bus.cpu_bus_cycle_status = (busy && phase != lbsd_pkg::LBSD_T4) ? stCode
                                     : `LBSD_ST_PASSIVE;
   assign bus.upper_byte_lane_enable_n = !(busy && wide);
   assign bus.hostAdOut = (phase == lbsd_pkg::LBSD_T1) ? addr[15:0] : reqData;
   assign bus.hostAdOe = busy && (phase == lbsd_pkg::LBSD_T1 || write);
   assign mapError = badMap;
   //==========================================
   // Cycle sequencer
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase <= lbsd_pkg::LBSD_T1;
         busy <= 1'b0;
         addr <= 20'h00000;
         write <= 1'b0;
         io <= 1'b0;
         wide <= 1'b0;
         waitCnt <= 2'h0;
         reqDone <= 1'b0;
         rdData <= 16'h0000;
      end
      else
      begin
         reqDone <= 1'b0;
         case (phase)
            lbsd_pkg::LBSD_T1:
            begin
               if (busy)
               begin
                  phase <= lbsd_pkg::LBSD_T2;
               end
               else if (reqValid && !reqDone)
               begin
                  busy <= 1'b1;
                  addr <= reqAddr;
                  write <= reqWrite;
                  io <= reqIo;
                  wide <= reqWide;
                  waitCnt <= waitStates;
               end
            end
            lbsd_pkg::LBSD_T2: phase <= lbsd_pkg::LBSD_T3;
            lbsd_pkg::LBSD_T3:
            begin
               if (waitCnt != 2'h0)
               begin
                  waitCnt <= waitCnt - 2'h1;
               end
               else
               begin
                  phase <= lbsd_pkg::LBSD_T4;
                  rdData <= bus.adIn;
               end
            end
            lbsd_pkg::LBSD_T4:
            begin
               phase <= lbsd_pkg::LBSD_T1;
               busy <= 1'b0;
               reqDone <= 1'b1;
            end
            default: phase <= lbsd_pkg::LBSD_T1;
         endcase
      end
   end
endmodule : lbsd_host_end

// ==== lbsd_bus_chk.sv ====
// Checker for the local bus between the host end and the device end.
// Assumes instantiation beside the bus interface, fed by its signals.
`timescale 1ns/10ps
`include "lbsd_params.svh"
module lbsd_bus_chk
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bus
   input wire logic [2:0] cpu_bus_cycle_status,
   input wire logic memory_window_select_n,
   input wire logic io_window_select_n,
   input wire logic hostAdOe,
   input wire logic devAdOe
);
   // ====
   // Cycle active marker, high while status is not passive
   logic active;
   assign active = cpu_bus_cycle_status != `LBSD_ST_PASSIVE;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   status_hold_a:
      assert property (active |=> !active || $stable(cpu_bus_cycle_status))
         else $error("status changed within a cycle");
   addr_phase_a:
      assert property ($rose(active) |-> hostAdOe && !devAdOe) else $error("no address in T1");
   no_clash_a:
      assert property (!(hostAdOe && devAdOe)) else $error("bus driven by both ends");
   unsel_float_a:
      assert property (devAdOe |-> !(memory_window_select_n && io_window_select_n))
         else $error("device drives while unselected");
   one_window_a:
      assert property (memory_window_select_n || io_window_select_n)
         else $error("both selects low");
   write_float_a:
      assert property (active && cpu_bus_cycle_status inside {`LBSD_ST_IOWR, `LBSD_ST_MEMWR}
         |=> !devAdOe [*3]) else $error("device drives in write cycle");
   mem_read_a:
      assert property (active && !memory_window_select_n && cpu_bus_cycle_status ==
         `LBSD_ST_MEMRD |-> ##[1:3] devAdOe) else $error("memory read not answered");
   io_read_a:
      assert property (active && !io_window_select_n && cpu_bus_cycle_status ==
         `LBSD_ST_IORD |-> ##[1:3] devAdOe) else $error("io read not answered");
   drive_end_a:
      assert property ($rose(devAdOe) |-> ##[2:5] !devAdOe) else $error("drive not released");
   sel_hold_a:
      assert property ($rose(active) |=> $stable({memory_window_select_n, io_window_select_n})
         [*3]) else $error("select changed mid cycle");
endmodule : lbsd_bus_chk

// ==== local_bus_select_decode_tb_top.sv ====
// Testbench joining host end and device end over the local bus.
// Assumes one shared clock; the checker sits beside the interface.
`timescale 1ns/10ps
module local_bus_select_decode_tb_top;
   logic clock = 0, reset_n = 0, reqValid = 0, reqWrite = 0, reqIo = 0, reqWide = 0;
   logic [19:0] reqAddr = '0;
   logic [15:0] reqData = '0, rdDataIn = 16'hA5C3, rdData, wrData;
   logic [1:0] waitStates = '0;
   logic [5:0] memBlock = 6'h05;
   logic [11:0] ioBase = 12'h0F3;
   logic [7:0] vecWriteIdx = '0;
   logic reqDone, mapError, accValid, accWrite, accIo, upperLane, wideHost, vecWriteAllowed;
   logic [13:0] memOffset;
   logic [3:0] ioOffset;
   int miscompares = 0, checked = 0, cycles = 0, accCount = 0, took, n;
   lbsd_bus_if i_lbsd_bus_if (.clock(clock));
   assign i_lbsd_bus_if.readyIn = 1'b1;
   lbsd_host_end i_lbsd_host_end (.clock(clock), .reset_n(reset_n), .bus(i_lbsd_bus_if.host),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqIo(reqIo), .reqWide(reqWide),
      .reqAddr(reqAddr), .reqData(reqData), .waitStates(waitStates), .memBlock(memBlock),
      .ioBase(ioBase), .reqDone(reqDone), .rdData(rdData), .mapError(mapError));
   lbsd_device_end i_lbsd_device_end (.clock(clock), .reset_n(reset_n),
      .bus(i_lbsd_bus_if.device), .accValid(accValid), .accWrite(accWrite), .accIo(accIo),
      .accIntAck(), .memOffset(memOffset), .ioOffset(ioOffset), .wrData(wrData),
      .upperLane(upperLane), .wideHost(wideHost), .rdDataIn(rdDataIn),
      .vecWriteIdx(vecWriteIdx), .vecWriteAllowed(vecWriteAllowed));
   lbsd_bus_chk i_lbsd_bus_chk (.clock(clock), .reset_n(reset_n),
      .cpu_bus_cycle_status(i_lbsd_bus_if.cpu_bus_cycle_status),
      .memory_window_select_n(i_lbsd_bus_if.memory_window_select_n),
      .io_window_select_n(i_lbsd_bus_if.io_window_select_n),
      .hostAdOe(i_lbsd_bus_if.hostAdOe), .devAdOe(i_lbsd_bus_if.devAdOe));
   always #50 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (accValid === 1'b1)
         accCount++;
      if (cycles == 3000)
      begin
         miscompares++;
         end_sim();
      end
   end
   // ====
   // Shared tasks
   task automatic cmp(input string name, input logic [19:0] exp, input logic [19:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   task automatic run_cycle(input logic wr, io, wide, input logic [19:0] addr,
      input logic [15:0] data, input logic [1:0] ws);
      @(posedge clock);
      #1 {reqWrite, reqIo, reqWide, reqAddr, reqData, waitStates} = {wr, io, wide, addr, data, ws};
      reqValid = 1;
      took = 0;
      do
      begin
         @(posedge clock);
         #1 took++;
      end
      while (reqDone !== 1'b1 && took < 20);
      cmp("reqDone", 1, reqDone);
      reqValid = 0;
   endtask : run_cycle
   // ====
   // Scenarios
   task automatic mem_read_test();
      run_cycle(0, 0, 0, {6'h05, 14'h1234}, 0, 0);
      cmp("took", 5, took);
      cmp("rdData", 16'hA5C3, rdData);
      cmp("memOffset", 14'h1234, memOffset);
      cmp("accIo", 0, accIo);
      cmp("wideHost", 0, wideHost);
   endtask : mem_read_test
   task automatic io_test();
      run_cycle(1, 1, 1, {8'h00, 12'h0F3A}, 16'h5AC3, 3);
      cmp("took", 8, took);
      cmp("ioOffset", 4'hA, ioOffset);
      cmp("accWrite", 1, accWrite);
      cmp("accIo", 1, accIo);
      cmp("upperLane", 1, upperLane);
      cmp("wrData", 16'h5AC3, wrData);
      cmp("wideHost", 1, wideHost);
      run_cycle(0, 1, 0, {8'h00, 12'h0F34}, 0, 1);
      cmp("rdData", 16'hA5C3, rdData);
      cmp("ioOffset", 4'h4, ioOffset);
   endtask : io_test
   task automatic unsel_test();
      n = accCount;
      run_cycle(0, 0, 0, {6'h09, 14'h0010}, 0, 0);
      cmp("accCount", n, accCount);
      memBlock = 6'h3F;
      #1 cmp("mapError", 1, mapError);
      run_cycle(0, 0, 0, {6'h3F, 14'h0010}, 0, 0);
      cmp("accCount", n, accCount);
      memBlock = 6'h00;
      #1 cmp("mapError", 1, mapError);
      run_cycle(0, 0, 0, {6'h00, 14'h0010}, 0, 0);
      cmp("accCount", n, accCount);
      memBlock = 6'h05;
      #1 cmp("mapError", 0, mapError);
      cmp("wideHost", 1, wideHost);
   endtask : unsel_test
   task automatic vec_test();
      logic [7:0] idx [3] = '{8'hDF, 8'hE0, 8'hFF};
      foreach (idx[i])
      begin
         vecWriteIdx = idx[i];
         #1 cmp("vecWriteAllowed", i == 0, vecWriteAllowed);
      end
   endtask : vec_test
   task automatic end_sim();
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (8) @(posedge clock);
      #1 reset_n = 1;
      mem_read_test();
      io_test();
      unsel_test();
      vec_test();
      end_sim();
   end
endmodule : local_bus_select_decode_tb_top
